// ==== pkg/smwt_pkg.sv ====
// Shared constants, types and timing decode helpers of the static memory waveform block.
//
// Summary of operation
// - A read lasts the total read count; read holds are total minus setup and pulse.
// - Every read and write timing value is kept per chip select, in master clocks.
// - Zero setup and hold keep read strobe and chip select low across back-to-back reads.
// - With read_ctrl_select high, data is captured where the read strobe rises.
// - With read_ctrl_select low, data is captured where the chip select rises.
// - Only read_ctrl_select picks the controlling read signal; timings are never compared.
// - A write lasts the total write count; write holds are total minus setup and pulse.
// - Chip select uses separate setup, pulse and hold values for writes.
// - In byte-write mode the byte_write_n lines of enabled bytes follow the write strobe waveform; write_enable_n stays high.
// - Zero write setup and hold keep chip select low across consecutive writes to one device, and the write strobe unless write_ctrl_select is high.
// - With write_ctrl_select high, data is driven from strobe setup end to cycle end.
// - With write_ctrl_select low, data is driven from chip-select setup end to cycle end.
// - Setup code is six bits: 128 times bit five plus bits four to zero.
// - Pulse code is seven bits: 256 times bit six plus bits five to zero.
// - Cycle code is nine bits: 256 times bits eight to seven plus bits six to zero.
// - Per chip select, setups, pulses and cycle totals are grouped in three registers.
// - Strobe-controlled write with zero hold keeps address, selects and chip select briefly.
// - One idle cycle is inserted between transfers to different chip selects.
// - During that idle cycle all byte, chip select and read strobe lines are high.
// - Read setup, pulse and hold count address valid, strobe fall, strobe rise, change.
// - In byte-select mode byte_select_n follows the address timing of each access; in byte-write mode it stays high.
// - One wait cycle separates a read from a following write, on top of others.
package smwt_pkg;

   localparam int NUM_CS_DEF = 8;
   localparam int CS_W       = 3;
   localparam int ADDR_W     = 26;
   localparam int DATA_W     = 32;
   localparam int BE_W       = 4;
   localparam int SETUP_W    = 6;
   localparam int PULSE_W    = 7;
   localparam int CYCLE_W    = 9;
   localparam int CNT_W      = 10;

   localparam logic [CNT_W-1:0] SETUP_MSB_WEIGHT = 10'h080;
   localparam logic [CNT_W-1:0] PULSE_MSB_WEIGHT = 10'h100;
   localparam logic [CNT_W-1:0] CYCLE_MSB_WEIGHT = 10'h100;
   localparam logic [CNT_W-1:0] CNT_ZERO         = 10'h000;
   localparam logic [CNT_W-1:0] CNT_ONE          = 10'h001;
   localparam logic [1:0]       CS_CHANGE_WAIT   = 2'h1;
   localparam logic [1:0]       RD_TO_WR_WAIT    = 2'h1;
   localparam logic [1:0]       IDLE_SATURATE    = 2'h2;
   localparam logic [BE_W-1:0]  LANES_INACTIVE   = 4'hF;

   typedef struct packed {
      logic [SETUP_W-1:0] cs_wr_setup;
      logic [SETUP_W-1:0] wr_strobe_setup;
      logic [SETUP_W-1:0] cs_rd_setup;
      logic [SETUP_W-1:0] rd_strobe_setup;
   } smwt_setup_t;

   typedef struct packed {
      logic [PULSE_W-1:0] cs_wr_pulse;
      logic [PULSE_W-1:0] wr_strobe_pulse;
      logic [PULSE_W-1:0] cs_rd_pulse;
      logic [PULSE_W-1:0] rd_strobe_pulse;
   } smwt_pulse_t;

   typedef struct packed {
      logic [CYCLE_W-1:0] wr_total_cycle;
      logic [CYCLE_W-1:0] rd_total_cycle;
   } smwt_cycle_t;

   typedef struct packed {
      logic byte_write_mode;
      logic write_ctrl_select;
      logic read_ctrl_select;
   } smwt_mode_t;

   // One chip select's view of setup_timing_reg, pulse_timing_reg, cycle_timing_reg
   // and chip_mode_config_reg.
   typedef struct packed {
      smwt_mode_t  mode;
      smwt_cycle_t cycle;
      smwt_pulse_t pulse;
      smwt_setup_t setup;
   } smwt_cs_cfg_t;

   typedef struct packed {
      logic [CNT_W-1:0] rd_setup;
      logic [CNT_W-1:0] rd_pulse;
      logic [CNT_W-1:0] rd_hold;
      logic [CNT_W-1:0] cs_rd_setup;
      logic [CNT_W-1:0] cs_rd_pulse;
      logic [CNT_W-1:0] cs_rd_hold;
      logic [CNT_W-1:0] rd_total;
      logic [CNT_W-1:0] wr_setup;
      logic [CNT_W-1:0] wr_pulse;
      logic [CNT_W-1:0] wr_hold;
      logic [CNT_W-1:0] cs_wr_setup;
      logic [CNT_W-1:0] cs_wr_pulse;
      logic [CNT_W-1:0] cs_wr_hold;
      logic [CNT_W-1:0] wr_total;
   } smwt_eff_t;

   typedef struct packed {
      logic              write;
      logic [CS_W-1:0]   cs;
      logic [BE_W-1:0]   be;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } smwt_req_t;

   typedef struct packed {
      logic            cs_n;
      logic            rd_n;
      logic            we_n;
      logic [BE_W-1:0] bw_n;
      logic [BE_W-1:0] bs_n;
      logic            oe;
   } smwt_pins_t;

   function automatic logic [CNT_W-1:0] smwt_setup_eff(input logic [SETUP_W-1:0] code);
      return (code[5] ? SETUP_MSB_WEIGHT : CNT_ZERO) + CNT_W'(code[4:0]);
   endfunction

   function automatic logic [CNT_W-1:0] smwt_pulse_eff(input logic [PULSE_W-1:0] code);
      return (code[6] ? PULSE_MSB_WEIGHT : CNT_ZERO) + CNT_W'(code[5:0]);
   endfunction

   function automatic logic [CNT_W-1:0] smwt_cycle_eff(input logic [CYCLE_W-1:0] code);
      return CNT_W'(CNT_W'(code[8:7]) * CYCLE_MSB_WEIGHT) + CNT_W'(code[6:0]);
   endfunction

endpackage

// ==== core/smwt_timing_decode.sv ====
// Decoder from one chip select's coded timing fields to effective cycle counts.
`timescale 1ns/1ps
module smwt_timing_decode (
   cfg,
   eff
);
   input  wire smwt_pkg::smwt_cs_cfg_t cfg;
   output smwt_pkg::smwt_eff_t         eff;

   always_comb begin
      eff.rd_setup    = smwt_pkg::smwt_setup_eff(cfg.setup.rd_strobe_setup);
      eff.cs_rd_setup = smwt_pkg::smwt_setup_eff(cfg.setup.cs_rd_setup);
      eff.wr_setup    = smwt_pkg::smwt_setup_eff(cfg.setup.wr_strobe_setup);
      eff.cs_wr_setup = smwt_pkg::smwt_setup_eff(cfg.setup.cs_wr_setup);
      eff.rd_pulse    = smwt_pkg::smwt_pulse_eff(cfg.pulse.rd_strobe_pulse);
      eff.cs_rd_pulse = smwt_pkg::smwt_pulse_eff(cfg.pulse.cs_rd_pulse);
      eff.wr_pulse    = smwt_pkg::smwt_pulse_eff(cfg.pulse.wr_strobe_pulse);
      eff.cs_wr_pulse = smwt_pkg::smwt_pulse_eff(cfg.pulse.cs_wr_pulse);
      eff.rd_total    = smwt_pkg::smwt_cycle_eff(cfg.cycle.rd_total_cycle);
      eff.wr_total    = smwt_pkg::smwt_cycle_eff(cfg.cycle.wr_total_cycle);
      // Holds are never programmed; they fall out of the totals.
      eff.rd_hold     = eff.rd_total - eff.rd_setup - eff.rd_pulse;
      eff.cs_rd_hold  = eff.rd_total - eff.cs_rd_setup - eff.cs_rd_pulse;
      eff.wr_hold     = eff.wr_total - eff.wr_setup - eff.wr_pulse;
      eff.cs_wr_hold  = eff.wr_total - eff.cs_wr_setup - eff.cs_wr_pulse;
   end

endmodule

// ==== core/smwt_core.sv ====
// Static memory waveform generator: access sequencing, strobe shaping and read capture.
`timescale 1ns/1ps
module smwt_core #(
   parameter int NUM_CS = smwt_pkg::NUM_CS_DEF
) (
   clk,
   rstn,
   cs_cfg,
   req_valid,
   req_ready,
   req,
   resp_done,
   resp_rdata,
   busy,
   addr_out,
   chip_select_n,
   read_strobe_n,
   write_enable_n,
   byte_write_n,
   byte_select_n,
   data_out,
   data_oe,
   data_in
);
   input  wire logic                              clk;
   input  wire logic                              rstn;
   input  wire smwt_pkg::smwt_cs_cfg_t            cs_cfg [NUM_CS];
   input  wire logic                              req_valid;
   output logic                                   req_ready;
   input  wire smwt_pkg::smwt_req_t               req;
   output logic                                   resp_done;
   output logic [smwt_pkg::DATA_W-1:0]            resp_rdata;
   output logic                                   busy;
   output logic [smwt_pkg::ADDR_W-1:0]            addr_out;
   output logic [NUM_CS-1:0]                      chip_select_n;
   output logic                                   read_strobe_n;
   output logic                                   write_enable_n;
   output logic [smwt_pkg::BE_W-1:0]              byte_write_n;
   output logic [smwt_pkg::BE_W-1:0]              byte_select_n;
   output logic [smwt_pkg::DATA_W-1:0]            data_out;
   output logic                                   data_oe;
   input  wire logic [smwt_pkg::DATA_W-1:0]       data_in;

   localparam int CNT_W = smwt_pkg::CNT_W;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_GAP  = 2'b01,
      ST_ACC  = 2'b10,
      ST_EXT  = 2'b11
   } smwt_state_t;

   if (NUM_CS < 1 || NUM_CS > (1 << smwt_pkg::CS_W)) begin : g_check
      $error("NUM_CS must lie between one and the chip-select field range");
   end

   logic                          rst_meta_reg;
   logic                          rst_sync_reg;
   logic [smwt_pkg::DATA_W-1:0]   din_meta_reg;
   logic [smwt_pkg::DATA_W-1:0]   din_sync_reg;
   smwt_state_t                   state_reg;
   smwt_state_t                   state_next;
   logic [CNT_W-1:0]              cnt_reg;
   logic [CNT_W-1:0]              cnt_next;
   logic [1:0]                    gap_reg;
   logic [1:0]                    gap_next;
   logic [1:0]                    idle_reg;
   logic [1:0]                    idle_next;
   smwt_pkg::smwt_req_t           cur_reg;
   smwt_pkg::smwt_req_t           cur_next;
   smwt_pkg::smwt_eff_t           eff_reg;
   smwt_pkg::smwt_eff_t           eff_next;
   smwt_pkg::smwt_mode_t          mode_reg;
   smwt_pkg::smwt_mode_t          mode_next;
   logic                          had_access_reg;
   smwt_pkg::smwt_eff_t           dec_eff;
   smwt_pkg::smwt_pins_t          pins_next;
   logic                          accept;
   logic                          last;
   logic                          ext_need;
   logic                          finish;
   logic                          capture;
   logic [1:0]                    gap_need;
   logic [CNT_W-1:0]              total_cur;
   logic [CNT_W-1:0]              rd_ctrl_end;

   // Only this copy of the reset reaches the rest of the block.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // The data pins come from another device and are resynchronised before use.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         din_meta_reg <= '0;
         din_sync_reg <= '0;
      end else begin
         din_meta_reg <= data_in;
         din_sync_reg <= din_meta_reg;
      end
   end

   // Decoding happens once at acceptance so the access runs on frozen counts.
   smwt_timing_decode u_decode (
      .cfg (cs_cfg[req.cs]),
      .eff (dec_eff)
   );

   function automatic logic in_pulse(
      input logic [CNT_W-1:0] cnt,
      input logic [CNT_W-1:0] setup,
      input logic [CNT_W-1:0] pulse
   );
      return (cnt >= setup) && (cnt < setup + pulse);
   endfunction

   function automatic smwt_pkg::smwt_pins_t shape(
      input smwt_state_t          st,
      input logic [CNT_W-1:0]     cnt,
      input smwt_pkg::smwt_req_t  r,
      input smwt_pkg::smwt_eff_t  e,
      input smwt_pkg::smwt_mode_t m
   );
      smwt_pkg::smwt_pins_t p;
      logic                 we_low;
      p.cs_n = 1'b1;
      p.rd_n = 1'b1;
      p.we_n = 1'b1;
      p.bw_n = smwt_pkg::LANES_INACTIVE;
      p.bs_n = smwt_pkg::LANES_INACTIVE;
      p.oe   = 1'b0;
      we_low = 1'b0;
      if (st == ST_ACC || st == ST_EXT) begin
         if (!m.byte_write_mode) begin
            p.bs_n = ~r.be;
         end
         if (!r.write) begin
            p.rd_n = !in_pulse(cnt, e.rd_setup, e.rd_pulse);
            p.cs_n = !in_pulse(cnt, e.cs_rd_setup, e.cs_rd_pulse);
         end else begin
            // The extension cycle keeps chip select where it was and lifts the strobe.
            we_low = (st == ST_ACC) && in_pulse(cnt, e.wr_setup, e.wr_pulse);
            p.cs_n = !in_pulse(cnt, e.cs_wr_setup, e.cs_wr_pulse);
            if (m.write_ctrl_select) begin
               p.oe = (cnt >= e.wr_setup);
            end else begin
               p.oe = (cnt >= e.cs_wr_setup);
            end
            if (m.byte_write_mode) begin
               p.bw_n = ~({smwt_pkg::BE_W{we_low}} & r.be);
            end else begin
               p.we_n = !we_low;
            end
         end
      end
      return p;
   endfunction

   always_comb begin
      total_cur = cur_reg.write ? eff_reg.wr_total : eff_reg.rd_total;
   end

   // A total below one still ends after one cycle, so a bad setting cannot hang the block.
   always_comb begin
      last = (state_reg == ST_ACC) && (cnt_reg + smwt_pkg::CNT_ONE >= total_cur);
   end

   // Zero hold on a strobe-controlled write buys one extra cycle of address and select.
   always_comb begin
      ext_need = last && cur_reg.write && mode_reg.write_ctrl_select
                 && (eff_reg.wr_hold == smwt_pkg::CNT_ZERO);
   end

   always_comb begin
      finish = (last && !ext_need) || (state_reg == ST_EXT);
   end

   always_comb begin
      req_ready = (state_reg == ST_IDLE) || finish;
   end

   always_comb begin
      accept = req_valid && req_ready;
   end

   always_comb begin
      busy = (state_reg != ST_IDLE);
   end

   // Idle cycles already spent on the bus count against the wait cycles still owed.
   always_comb begin
      gap_need = 2'h0;
      if (had_access_reg) begin
         if (req.cs != cur_reg.cs) begin
            gap_need = gap_need + smwt_pkg::CS_CHANGE_WAIT;
         end
         if (!cur_reg.write && req.write) begin
            gap_need = gap_need + smwt_pkg::RD_TO_WR_WAIT;
         end
      end
      if (state_reg == ST_IDLE) begin
         gap_need = (gap_need > idle_reg) ? gap_need - idle_reg : 2'h0;
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      gap_next   = gap_reg;
      cur_next   = cur_reg;
      eff_next   = eff_reg;
      mode_next  = mode_reg;
      unique case (state_reg)
         ST_IDLE: begin
            state_next = ST_IDLE;
         end
         ST_GAP: begin
            if (gap_reg == 2'h0) begin
               state_next = ST_ACC;
               cnt_next   = smwt_pkg::CNT_ZERO;
            end else begin
               gap_next = gap_reg - 2'h1;
            end
         end
         ST_ACC: begin
            if (ext_need) begin
               state_next = ST_EXT;
            end else if (last) begin
               state_next = ST_IDLE;
            end else begin
               cnt_next = cnt_reg + smwt_pkg::CNT_ONE;
            end
         end
         ST_EXT: begin
            state_next = ST_IDLE;
         end
      endcase
      // Same device, no wait owed: the next access starts on the very next edge.
      if (accept) begin
         cur_next  = req;
         eff_next  = dec_eff;
         mode_next = cs_cfg[req.cs].mode;
         cnt_next  = smwt_pkg::CNT_ZERO;
         if (gap_need == 2'h0) begin
            state_next = ST_ACC;
         end else begin
            state_next = ST_GAP;
            gap_next   = gap_need - 2'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= smwt_pkg::CNT_ZERO;
         gap_reg   <= 2'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         gap_reg   <= gap_next;
      end
   end

   // Request fields are copied at acceptance and stay put while the access runs.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         cur_reg        <= '0;
         eff_reg        <= '0;
         mode_reg       <= '0;
         had_access_reg <= 1'b0;
      end else begin
         cur_reg  <= cur_next;
         eff_reg  <= eff_next;
         mode_reg <= mode_next;
         if (accept) begin
            had_access_reg <= 1'b1;
         end
      end
   end

   always_comb begin
      idle_next = idle_reg;
      if (state_next != ST_IDLE) begin
         idle_next = 2'h0;
      end else if (idle_reg != smwt_pkg::IDLE_SATURATE) begin
         idle_next = idle_reg + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         idle_reg <= 2'h0;
      end else begin
         idle_reg <= idle_next;
      end
   end

   // Pins are registered from the next state, so each pin edge lines up with its count.
   always_comb begin
      pins_next = shape(state_next, cnt_next, cur_next, eff_next, mode_next);
   end

   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         chip_select_n  <= '1;
         read_strobe_n  <= 1'b1;
         write_enable_n <= 1'b1;
         byte_write_n   <= smwt_pkg::LANES_INACTIVE;
         byte_select_n  <= smwt_pkg::LANES_INACTIVE;
         data_oe        <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_CS; i++) begin
            chip_select_n[i] <= pins_next.cs_n || (cur_next.cs != smwt_pkg::CS_W'(i));
         end
         read_strobe_n  <= pins_next.rd_n;
         write_enable_n <= pins_next.we_n;
         byte_write_n   <= pins_next.bw_n;
         byte_select_n  <= pins_next.bs_n;
         data_oe        <= pins_next.oe;
      end
   end

   // Address and data keep their last value between accesses to save toggling.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         addr_out <= '0;
         data_out <= '0;
      end else if (state_next == ST_ACC) begin
         addr_out <= cur_next.addr;
         data_out <= cur_next.wdata;
      end
   end

   // The mode bit alone picks the controlling signal; the two waveforms are not compared.
   always_comb begin
      if (mode_reg.read_ctrl_select) begin
         rd_ctrl_end = eff_reg.rd_setup + eff_reg.rd_pulse - smwt_pkg::CNT_ONE;
      end else begin
         rd_ctrl_end = eff_reg.cs_rd_setup + eff_reg.cs_rd_pulse - smwt_pkg::CNT_ONE;
      end
   end

   // The edge that ends this cycle is the one that raises the controlling pin.
   always_comb begin
      capture = (state_reg == ST_ACC) && !cur_reg.write && (cnt_reg == rd_ctrl_end);
   end

   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         resp_rdata <= '0;
      end else if (capture) begin
         resp_rdata <= din_sync_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         resp_done <= 1'b0;
      end else begin
         resp_done <= finish;
      end
   end

endmodule

// ==== tb/smwt_props.sv ====
// Port-level assertion checker of the static memory waveform generator.
`timescale 1ns/1ps
module smwt_props #(parameter int NUM_CS = 8) (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire logic              resp_done,
   input wire logic              busy,
   input wire logic [NUM_CS-1:0] chip_select_n,
   input wire logic              read_strobe_n,
   input wire logic              write_enable_n,
   input wire logic [3:0]        byte_write_n,
   input wire logic [3:0]        byte_select_n,
   input wire logic              data_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_reset_quiet: assert property ($rose(rstn) |->
      &chip_select_n && read_strobe_n && write_enable_n && !data_oe) else $error("pins active");
   a_idle_quiet: assert property (!busy |-> &chip_select_n && read_strobe_n &&
      write_enable_n && &byte_write_n && &byte_select_n && !data_oe) else $error("idle pins");
   a_ready_idle: assert property (!busy |-> req_ready) else $error("idle not ready");
   a_take_busy: assert property (req_valid && req_ready |=> busy)
      else $error("request dropped");
   a_cs_onehot: assert property ($onehot0(~chip_select_n)) else $error("two selects");
   a_rd_wr_excl: assert property (!read_strobe_n |->
      write_enable_n && &byte_write_n && !data_oe) else $error("read overlaps write");
   // Two different selects low on adjacent cycles means the idle cycle went missing.
   a_cs_gap: assert property (!(&$past(chip_select_n)) && !(&chip_select_n) |->
      chip_select_n == $past(chip_select_n)) else $error("select switched without idle");
   a_done_ready: assert property (resp_done |-> $past(req_ready))
      else $error("done without final cycle");
   a_bw_mode: assert property (byte_write_n != 4'hF |->
      write_enable_n && byte_select_n == 4'hF) else $error("byte write mixed");
   a_done_bound: assert property ($rose(busy) |-> ##[1:1000] resp_done)
      else $error("access never completed");
   c_write: cover property (!write_enable_n ##[1:20] resp_done);
   c_bytewr: cover property (byte_write_n != 4'hF);
   c_read: cover property ($rose(read_strobe_n) ##[1:3] resp_done);
endmodule
bind smwt_core smwt_props #(.NUM_CS(NUM_CS)) props_u (.clk(clk), .rstn(rstn),
   .req_valid(req_valid), .req_ready(req_ready), .resp_done(resp_done), .busy(busy),
   .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
   .write_enable_n(write_enable_n), .byte_write_n(byte_write_n),
   .byte_select_n(byte_select_n), .data_oe(data_oe));

// ==== tb/smwt_mem_model.sv ====
// Behavioural asynchronous memory on the far side of the strobes.
`timescale 1ns/1ps
module smwt_mem_model (
   input wire logic        clk,
   input wire logic [7:0]  chip_select_n,
   input wire logic        read_strobe_n,
   input wire logic        write_enable_n,
   input wire logic [3:0]  byte_write_n,
   input wire logic [3:0]  byte_select_n,
   input wire logic [25:0] addr_out,
   input wire logic [31:0] data_out,
   input wire logic        data_oe,
   output logic [31:0]     data_in
);
   logic [31:0] mem [16];
   logic [3:0]  lane;
   logic        sel;
   initial foreach (mem[i]) mem[i] = 32'h0;
   assign sel = chip_select_n != 8'hFF;
   // A released bus shows the inverse word, so a capture outside the strobe cannot match.
   assign data_in = (sel && !read_strobe_n) ? mem[addr_out[3:0]] : ~mem[addr_out[3:0]];
   assign lane = (byte_write_n != 4'hF) ? ~byte_write_n :
                 (write_enable_n ? 4'h0 : ~byte_select_n);
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         if (lane[i] && sel && data_oe) begin
            mem[addr_out[3:0]][8*i +: 8] <= data_out[8*i +: 8];
         end
      end
   end
endmodule

// ==== tb/smwt_core_tb.sv ====
// Self-checking bench of the static memory waveform generator.
`timescale 1ns/1ps
module smwt_core_tb;
   logic                   clk = 1'b0;
   logic                   rstn = 1'b0;
   logic                   req_valid = 1'b0;
   smwt_pkg::smwt_req_t    req = '0;
   smwt_pkg::smwt_cs_cfg_t cfg [8];
   logic                   req_ready, resp_done, busy, read_strobe_n, write_enable_n, data_oe;
   logic [31:0]            resp_rdata, data_out, data_in;
   logic [25:0]            addr_out;
   logic [7:0]             chip_select_n;
   logic [3:0]             byte_write_n, byte_select_n;
   int                     error_cnt = 0;
   int                     tests_run = 0;
   int                     cyc = 0;
   always #20 clk = ~clk;
   smwt_core #(.NUM_CS(8)) dut_u (.clk(clk), .rstn(rstn), .cs_cfg(cfg),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .resp_done(resp_done),
      .resp_rdata(resp_rdata), .busy(busy), .addr_out(addr_out),
      .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
      .write_enable_n(write_enable_n), .byte_write_n(byte_write_n),
      .byte_select_n(byte_select_n), .data_out(data_out), .data_oe(data_oe),
      .data_in(data_in));
   smwt_mem_model mem_u (.clk(clk), .chip_select_n(chip_select_n),
      .read_strobe_n(read_strobe_n), .write_enable_n(write_enable_n),
      .byte_write_n(byte_write_n), .byte_select_n(byte_select_n), .addr_out(addr_out),
      .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
   task automatic wrap_up();
      $display("Counts: %0d checks, %0d errors", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Two idle cycles before each request remove every automatic wait from the count.
   task automatic acc(input logic wr, input logic [2:0] cs, input logic [3:0] be,
         input logic [25:0] a, input logic [31:0] d, output logic [31:0] q, output int n);
      repeat (2) @(negedge clk);
      req_valid = 1'b1;
      req = '{wr, cs, be, a, d};
      #1;
      for (n = 0; req_ready !== 1'b1 && n < 2000; n++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (n = 1; resp_done !== 1'b1 && n < 2000; n++) @(negedge clk);
      q = resp_rdata;
   endtask
   task automatic t_sel_path();
      logic [31:0] q;
      int          n;
      acc(1'b1, 3'h0, 4'hF, 26'h3, 32'h5A5A0F0F, q, n);
      chk("write cycles", 32'h6, 32'(n));
      acc(1'b1, 3'h2, 4'hF, 26'h4, 32'h12345678, q, n);
      chk("zero hold write cycles", 32'h7, 32'(n));
      acc(1'b0, 3'h0, 4'hF, 26'h3, 32'h0, q, n);
      chk("read cycles", 32'h6, 32'(n));
      chk("strobe read data", 32'h5A5A0F0F, q);
      $display("Test sel_path done");
   endtask
   task automatic t_byte_path();
      logic [31:0] q;
      int          n;
      acc(1'b1, 3'h1, 4'hF, 26'h5, 32'hA1B2C3D4, q, n);
      acc(1'b1, 3'h1, 4'h5, 26'h5, 32'h0, q, n);
      acc(1'b0, 3'h1, 4'hF, 26'h5, 32'h0, q, n);
      chk("select read cycles", 32'h7, 32'(n));
      chk("byte lane merge", 32'hA100C300, q);
      acc(1'b0, 3'h2, 4'hF, 26'h4, 32'h0, q, n);
      chk("held write data", 32'h12345678, q);
      $display("Test byte_path done");
   endtask
   // Requests held back to back: two reads on device 0, then a write owing two waits.
   task automatic t_gap_path();
      int hi;
      hi = 0;
      repeat (2) @(negedge clk);
      req_valid = 1'b1;
      req = '{1'b0, 3'h0, 4'hF, 26'h3, 32'h0};
      @(negedge clk);
      repeat (5) begin
         hi += chip_select_n[0];
         @(negedge clk);
      end
      chk("first read done", 32'h1, 32'(resp_done));
      req = '{1'b1, 3'h1, 4'hF, 26'h6, 32'h0F1E2D3C};
      repeat (5) begin
         hi += chip_select_n[0];
         @(negedge clk);
      end
      chk("select held across reads", 32'h0, 32'(hi));
      chk("second read done", 32'h1, 32'(resp_done));
      chk("back to back read data", 32'h5A5A0F0F, resp_rdata);
      chk("select change idle", 32'h1FF, {23'h0, chip_select_n, read_strobe_n});
      req_valid = 1'b0;
      @(negedge clk);
      chk("wait cycle pins", 32'h1FF, {23'h0, chip_select_n, read_strobe_n});
      repeat (6) @(negedge clk);
      chk("read to write wait", 32'h1, 32'(resp_done));
      $display("Test gap_path done");
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      foreach (cfg[i]) cfg[i] = '0;
      // Nonzero strobe setups and nonzero pulses, sums within the totals.
      cfg[0] = {3'h3, 9'h5, 9'h5, 7'h5, 7'h3, 7'h5, 7'h3, 6'h0, 6'h1, 6'h0, 6'h1};
      cfg[1] = {3'h4, 9'h5, 9'h6, 7'h3, 7'h2, 7'h3, 7'h4, 6'h1, 6'h1, 6'h1, 6'h1};
      cfg[2] = {3'h3, 9'h5, 9'h6, 7'h5, 7'h4, 7'h5, 7'h4, 6'h0, 6'h1, 6'h0, 6'h1};
      repeat (4) @(negedge clk);
      chk("reset pins", 32'h7FFFE, {13'h0, chip_select_n, read_strobe_n, write_enable_n,
         byte_write_n, byte_select_n, data_oe});
      rstn = 1'b1;
      repeat (4) @(negedge clk);
      t_sel_path();
      t_byte_path();
      t_gap_path();
      wrap_up();
   end
endmodule
